// File: pwr_pkg.sv
// Register map, field layout, reset values and encodings of the port policing and drop block
package pwr_pkg;

    // ------------------------------------------------------------
    // Register byte offsets within the port window
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_POINTER     = 12'h804;
    localparam logic [11:0] OFS_CONTROL     = 12'h80c;
    localparam logic [11:0] OFS_RATE        = 12'h820;
    localparam logic [11:0] OFS_BURST       = 12'h824;
    localparam logic [11:0] OFS_MEM_THR     = 12'h830;
    localparam logic [11:0] OFS_MEM_SCALE   = 12'h834;
    localparam logic [11:0] OFS_Q_THR       = 12'h840;
    localparam logic [11:0] OFS_Q_SCALE     = 12'h844;
    localparam logic [11:0] OFS_COUNTER     = 12'h850;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTL_ENABLE       = 0;
    localparam int CTL_BLIND        = 1;
    localparam int CTL_DROP_SRP     = 2;
    localparam int CTL_REMAP        = 3;
    localparam int CTL_MARK         = 4;
    localparam int CTL_NONIP_LO     = 5;
    localparam int CTL_PORT_BASED   = 7;
    localparam int CTL_CNT_SEL_LO   = 8;
    localparam int CTL_DROP_ALL     = 10;
    localparam int CTL_DROPPED_ONLY = 11;
    localparam int CTL_W            = 12;
    localparam int HI_LO            = 16;
    localparam int FLD_W            = 11;
    localparam int PTR_PORT_LO      = 16;
    localparam int PTR_QUEUE_LO     = 0;
    localparam int PROB_SHIFT       = 6;
    localparam int RAND_W           = 16;

    // ------------------------------------------------------------
    // Reset values and write masks
    // ------------------------------------------------------------
    localparam logic [11:0] CTL_RESET       = 12'h020;
    localparam logic [31:0] RATE_RESET      = 32'h1000_2000;
    localparam logic [31:0] BURST_RESET     = 32'h1000_3000;
    localparam logic [10:0] MEM_MAX_RESET   = 11'h400;
    localparam logic [10:0] MEM_MIN_RESET   = 11'h080;
    localparam logic [10:0] MEM_SCALE_RESET = 11'h020;
    localparam logic [31:0] Q_THR_RESET     = 32'h0080_0009;
    localparam logic [31:0] Q_SCALE_RESET   = 32'h0010_0000;
    localparam logic [31:0] THR_MASK        = 32'h07ff_07ff;
    localparam logic [31:0] SCALE_MASK      = 32'h07ff_0000;
    localparam logic [16:0] BKT_C_RESET     = 17'h0_1000;
    localparam logic [16:0] BKT_P_RESET     = 17'h0_3000;

    // ------------------------------------------------------------
    // Colour codes, shared with the counter select field
    // ------------------------------------------------------------
    localparam logic [1:0] COL_DROPPED = 2'b00;
    localparam logic [1:0] COL_GREEN   = 2'b01;
    localparam logic [1:0] COL_YELLOW  = 2'b10;
    localparam logic [1:0] COL_RED     = 2'b11;

    typedef enum logic [2:0] {
        BUS_IDLE   = 3'b001,
        BUS_RD_MEM = 3'b010,
        BUS_RD_OUT = 3'b100
    } pwr_bus_state_t;

endpackage : pwr_pkg

// File: pwr_entry_mem.sv
// Indirect per-port per-queue setting store, one write port and two registered read ports
`timescale 1ns/100ps
module pwr_entry_mem
#(
    parameter int              WORDS  = 4,
    parameter int              WORD_W = 32,
    parameter int              DEPTH  = 32,
    parameter int              AW     = 5,
    parameter logic [127:0]    INIT   = '0
)
(
    input  logic                      clk,
    input  logic                      rst,
    input  logic                      ce,
    input  logic [WORDS-1:0]          we,
    input  logic [AW-1:0]             waddr,
    input  logic [WORDS*WORD_W-1:0]   wdata,
    input  logic [AW-1:0]             a_addr,
    output logic [WORDS*WORD_W-1:0]   a_data,
    input  logic [AW-1:0]             b_addr,
    output logic [WORDS*WORD_W-1:0]   b_data
);

    if (WORDS * WORD_W > 128 || DEPTH > (1 << AW) || DEPTH < 2)
    begin : g_bad_size
        $error("pwr_entry_mem: unsupported shape");
    end

    for (genvar w = 0; w < WORDS; w++)
    begin : g_lane
        logic [WORD_W-1:0] store [DEPTH];
        logic [WORD_W-1:0] a_q;
        logic [WORD_W-1:0] b_q;

        always_ff @(posedge clk)
        begin
            if (rst)
            begin
                for (int i = 0; i < DEPTH; i++)
                    store[i] <= INIT[w*WORD_W +: WORD_W];
            end
            else if (ce && we[w])
                store[waddr] <= wdata[w*WORD_W +: WORD_W];
        end

        always_ff @(posedge clk)
        begin
            if (rst)
            begin
                a_q <= '0;
                b_q <= '0;
            end
            else if (ce)
            begin
                a_q <= store[a_addr];
                b_q <= store[b_addr];
            end
        end

        assign a_data[w*WORD_W +: WORD_W] = a_q;
        assign b_data[w*WORD_W +: WORD_W] = b_q;
    end

endmodule : pwr_entry_mem

// File: pwr_top.sv
// Port ingress policing and weighted random drop: AHB-Lite registers and per-packet decision
//
// Summary of operation
// - Enable bit turns policing and drop on
// - Mode bit selects colour blind or aware
// - SRP frames dropped only when allowed, or when red
// - Remap bit meters aware colour, else unchanged
// - Mark bit enables colour marking output
// - Non-IP frames take default colour field
// - Port-based bit picks own or index-zero rates
// - Select field picks counter red/yellow/green/dropped
// - Drop-all discards above memory max, SRP frames only when allowed
// - Counters count dropped only or all
// - Rate register holds committed and peak rate
// - Burst register holds committed and peak burst
// - Memory thresholds: eleven-bit max and min
// - Memory scale writable, average read-only
// - Queue thresholds per selected port, queue
// - Queue scale writable per selected entry
// - Queue average read-only, writes ignored
// - Pointer port index selects indirect entry
// - Pointer queue field selects indirect entry
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/100ps
module pwr_top
    import pwr_pkg::*;
#(
    parameter logic [2:0] THIS_PORT = 3'h1,
    parameter int         CNT_W     = 24
)
(
    input  logic              clk,
    input  logic              rst,
    input  logic              ce,
    input  logic              hsel,
    input  logic [31:0]       haddr,
    input  logic [1:0]        htrans,
    input  logic              hwrite,
    input  logic [2:0]        hsize,
    input  logic [31:0]       hwdata,
    input  logic              hready,
    output logic [31:0]       hrdata,
    output logic              hreadyout,
    output logic              hresp,
    input  logic              pkt_valid,
    input  logic [1:0]        pkt_queue,
    input  logic [15:0]       pkt_len,
    input  logic              pkt_is_ip,
    input  logic [1:0]        pkt_dscp_colour,
    input  logic              pkt_srp,
    input  logic [RAND_W-1:0] pkt_rand,
    input  logic [10:0]       pkt_queue_avg,
    input  logic [10:0]       mem_avg_size,
    output logic              res_valid,
    output logic [1:0]        res_queue,
    output logic [1:0]        res_colour,
    output logic              res_drop,
    output logic              res_mark
);

    if (CNT_W < 1 || CNT_W > 32 || THIS_PORT > 3'h6)
    begin : g_bad_param
        $error("pwr_top: counter width or port number out of range");
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [CTL_W-1:0]  ctrl;
    logic [2:0]        port_idx;
    logic [1:0]        queue_ptr;
    logic [10:0]       mem_max;
    logic [10:0]       mem_min;
    logic [10:0]       mem_scale;
    logic [10:0]       mem_avg;
    logic [10:0]       q_avg [4];
    logic [CNT_W-1:0]  cnt [4][4];

    logic              dp_write;
    logic [11:0]       dp_addr;
    logic [11:0]       rd_addr;
    pwr_bus_state_t    bus_state;
    logic [31:0]       read_value;
    logic              accept;
    logic              own_port;

    logic [3:0]        mem_we;
    logic [127:0]      mem_wdata;
    logic [127:0]      a_data;
    logic [127:0]      b_data;
    logic [4:0]        b_addr;
    logic [2:0]        pol_port;

    assign accept   = hsel && htrans[1] && hready;
    assign own_port = (port_idx == THIS_PORT);
    assign pol_port = ctrl[CTL_PORT_BASED] ? THIS_PORT : 3'h0;

    // ------------------------------------------------------------
    // AHB-Lite slave: writes take no wait, reads take two
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            dp_write <= 1'b0;
            dp_addr  <= '0;
        end
        else if (ce)
        begin
            dp_write <= accept && hwrite;
            if (accept)
                dp_addr <= {haddr[11:2], 2'b00};
        end
    end

    // Extra wait lets a write in the previous data phase land before the entry is read
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            bus_state <= BUS_IDLE;
            hreadyout <= 1'b1;
            hrdata    <= '0;
            hresp     <= 1'b0;
            rd_addr   <= '0;
        end
        else if (ce)
        begin
            unique case (bus_state)
                BUS_IDLE:
                begin
                    if (accept && !hwrite)
                    begin
                        bus_state <= BUS_RD_MEM;
                        hreadyout <= 1'b0;
                        rd_addr   <= {haddr[11:2], 2'b00};
                    end
                end
                BUS_RD_MEM:
                begin
                    bus_state <= BUS_RD_OUT;
                end
                BUS_RD_OUT:
                begin
                    bus_state <= BUS_IDLE;
                    hreadyout <= 1'b1;
                    hrdata    <= read_value;
                end
                default:
                begin
                    bus_state <= BUS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    always_comb
    begin
        read_value = '0;
        unique case (rd_addr)
            OFS_POINTER:   read_value = {13'h0, port_idx, 14'h0, queue_ptr};
            OFS_CONTROL:   read_value = {20'h0_0000, ctrl};
            OFS_RATE:      read_value = a_data[127:96];
            OFS_BURST:     read_value = a_data[95:64];
            OFS_MEM_THR:   read_value = {5'h0, mem_max, 5'h0, mem_min};
            OFS_MEM_SCALE: read_value = {5'h0, mem_scale, 5'h0, mem_avg};
            OFS_Q_THR:     read_value = a_data[63:32];
            OFS_Q_SCALE:
                read_value = a_data[31:0] | (own_port ? {21'h0, q_avg[queue_ptr]} : 32'h0);
            OFS_COUNTER:
                read_value = own_port ?
                    32'(cnt[queue_ptr][ctrl[CTL_CNT_SEL_LO +: 2]]) : 32'h0;
            default:       read_value = '0;
        endcase
    end

    // ------------------------------------------------------------
    // Direct registers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            port_idx  <= '0;
            queue_ptr <= '0;
            ctrl      <= CTL_RESET;
        end
        else if (ce && dp_write)
        begin
            if (dp_addr == OFS_POINTER)
            begin
                port_idx  <= hwdata[PTR_PORT_LO +: 3];
                queue_ptr <= hwdata[PTR_QUEUE_LO +: 2];
            end
            if (dp_addr == OFS_CONTROL)
                ctrl <= hwdata[CTL_W-1:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mem_max   <= MEM_MAX_RESET;
            mem_min   <= MEM_MIN_RESET;
            mem_scale <= MEM_SCALE_RESET;
        end
        else if (ce && dp_write)
        begin
            if (dp_addr == OFS_MEM_THR)
            begin
                mem_max <= hwdata[HI_LO +: FLD_W];
                mem_min <= hwdata[FLD_W-1:0];
            end
            if (dp_addr == OFS_MEM_SCALE)
                mem_scale <= hwdata[HI_LO +: FLD_W];
        end
    end

    // ------------------------------------------------------------
    // Indirect entries, addressed by port index and queue pointer
    // ------------------------------------------------------------
    always_comb
    begin
        mem_we[3] = dp_write && (dp_addr == OFS_RATE);
        mem_we[2] = dp_write && (dp_addr == OFS_BURST);
        mem_we[1] = dp_write && (dp_addr == OFS_Q_THR);
        mem_we[0] = dp_write && (dp_addr == OFS_Q_SCALE);
        mem_wdata = {hwdata, hwdata, hwdata & THR_MASK, hwdata & SCALE_MASK};
    end

    pwr_entry_mem
    #(
        .WORDS  (4),
        .WORD_W (32),
        .DEPTH  (32),
        .AW     (5),
        .INIT   ({RATE_RESET, BURST_RESET, Q_THR_RESET, Q_SCALE_RESET})
    )
    u_entries
    (
        .clk    (clk),
        .rst    (rst),
        .ce     (ce),
        .we     (mem_we),
        .waddr  ({port_idx, queue_ptr}),
        .wdata  (mem_wdata),
        .a_addr ({port_idx, queue_ptr}),
        .a_data (a_data),
        .b_addr (b_addr),
        .b_data (b_data)
    );

    // ------------------------------------------------------------
    // Packet stage 0: entry lookup, or bucket refill scan when idle
    // ------------------------------------------------------------
    logic [1:0]        scan_q;
    logic              s1_valid;
    logic              s1_refill;
    logic [1:0]        s1_queue;
    logic [16:0]       s1_len;
    logic [1:0]        s1_in_colour;
    logic              s1_srp;
    logic [RAND_W-1:0] s1_rand;

    assign b_addr = {pol_port, pkt_valid ? pkt_queue : scan_q};

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            scan_q       <= '0;
            s1_valid     <= 1'b0;
            s1_refill    <= 1'b0;
            s1_queue     <= '0;
            s1_len       <= '0;
            s1_in_colour <= COL_GREEN;
            s1_srp       <= 1'b0;
            s1_rand      <= '0;
        end
        else if (ce)
        begin
            s1_valid  <= 1'b1;
            s1_refill <= !pkt_valid;
            s1_queue  <= pkt_valid ? pkt_queue : scan_q;
            s1_len    <= {1'b0, pkt_len};
            s1_in_colour <= pkt_is_ip ? pkt_dscp_colour
                                      : ctrl[CTL_NONIP_LO +: 2];
            s1_srp    <= pkt_srp;
            s1_rand   <= pkt_rand;
            if (!pkt_valid)
                scan_q <= scan_q + 2'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mem_avg <= '0;
            for (int q = 0; q < 4; q++)
                q_avg[q] <= '0;
        end
        else if (ce)
        begin
            mem_avg <= mem_avg_size;
            if (pkt_valid)
                q_avg[pkt_queue] <= pkt_queue_avg;
        end
    end

    // ------------------------------------------------------------
    // Packet stage 1: meter, drop decision, bucket update
    // ------------------------------------------------------------
    logic [16:0] bkt_c [4];
    logic [16:0] bkt_p [4];
    logic [16:0] rate_c;
    logic [16:0] rate_p;
    logic [16:0] burst_c;
    logic [16:0] burst_p;
    logic        c_ok;
    logic        p_ok;
    logic [1:0]  meter_colour;
    logic [1:0]  fin_colour;
    logic        wred_drop;
    logic        drop;
    logic        is_pkt;

    function automatic logic wred_hit(input logic [10:0]       avg,
                                      input logic [10:0]       min_t,
                                      input logic [10:0]       max_t,
                                      input logic [10:0]       scale,
                                      input logic              drop_all,
                                      input logic [RAND_W-1:0] rnd);
        logic [21:0] prob;
        prob = 22'(avg - min_t) * 22'(scale);
        if (avg < min_t)
            return 1'b0;
        if (avg > max_t && drop_all)
            return 1'b1;
        return prob[PROB_SHIFT +: RAND_W] > rnd;
    endfunction : wred_hit

    always_comb
    begin
        rate_c  = {1'b0, b_data[127:112]};
        rate_p  = {1'b0, b_data[111:96]};
        burst_c = {1'b0, b_data[95:80]};
        burst_p = {1'b0, b_data[79:64]};
        is_pkt  = s1_valid && !s1_refill;
        c_ok    = bkt_c[s1_queue] >= s1_len;
        p_ok    = bkt_p[s1_queue] >= s1_len;
        if (ctrl[CTL_BLIND])
            meter_colour = !p_ok ? COL_RED : (!c_ok ? COL_YELLOW : COL_GREEN);
        else if (s1_in_colour == COL_RED || !p_ok)
            meter_colour = COL_RED;
        else if (s1_in_colour == COL_YELLOW || !c_ok)
            meter_colour = COL_YELLOW;
        else
            meter_colour = COL_GREEN;
        if (!ctrl[CTL_ENABLE])
            fin_colour = s1_in_colour;
        else if (!ctrl[CTL_BLIND] && !ctrl[CTL_REMAP])
            fin_colour = s1_in_colour;
        else
            fin_colour = meter_colour;
        if (fin_colour == COL_DROPPED)
            fin_colour = COL_GREEN;
        wred_drop = wred_hit(mem_avg, mem_min, mem_max, mem_scale,
                             ctrl[CTL_DROP_ALL], s1_rand)
                 || wred_hit(q_avg[s1_queue], b_data[42:32], b_data[58:48],
                             b_data[26:16], 1'b0, s1_rand);
        if (s1_srp && !ctrl[CTL_DROP_SRP])
            wred_drop = 1'b0;
        drop = ctrl[CTL_ENABLE] && ((fin_colour == COL_RED) || wred_drop);
    end

    // Refill adds one rate quantum per scan visit, so a rate is bytes per four idle cycles
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int q = 0; q < 4; q++)
            begin
                bkt_c[q] <= BKT_C_RESET;
                bkt_p[q] <= BKT_P_RESET;
            end
        end
        else if (ce && s1_valid)
        begin
            if (s1_refill)
            begin
                bkt_c[s1_queue] <= (bkt_c[s1_queue] + rate_c > burst_c) ?
                                   burst_c : bkt_c[s1_queue] + rate_c;
                bkt_p[s1_queue] <= (bkt_p[s1_queue] + rate_p > burst_p) ?
                                   burst_p : bkt_p[s1_queue] + rate_p;
            end
            else if (ctrl[CTL_ENABLE] && !drop)
            begin
                if (fin_colour == COL_GREEN && c_ok)
                    bkt_c[s1_queue] <= bkt_c[s1_queue] - s1_len;
                if (fin_colour != COL_RED && p_ok)
                    bkt_p[s1_queue] <= bkt_p[s1_queue] - s1_len;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            res_valid  <= 1'b0;
            res_queue  <= '0;
            res_colour <= COL_GREEN;
            res_drop   <= 1'b0;
            res_mark   <= 1'b0;
        end
        else if (ce)
        begin
            res_valid  <= is_pkt;
            res_queue  <= s1_queue;
            res_colour <= fin_colour;
            res_drop   <= is_pkt && drop;
            res_mark   <= is_pkt && ctrl[CTL_ENABLE] && ctrl[CTL_MARK];
        end
    end

    // ------------------------------------------------------------
    // Colour counters of this port, per queue and per kind
    // ------------------------------------------------------------
    for (genvar q = 0; q < 4; q++)
    begin : g_cq
        for (genvar k = 0; k < 4; k++)
        begin : g_ck
            logic hit;
            assign hit = is_pkt && ctrl[CTL_ENABLE] && (s1_queue == 2'(q)) &&
                         ((k == 0) ? drop
                                   : (fin_colour == 2'(k) &&
                                      (drop || !ctrl[CTL_DROPPED_ONLY])));
            always_ff @(posedge clk)
            begin
                if (rst)
                    cnt[q][k] <= '0;
                else if (ce && hit)
                    cnt[q][k] <= cnt[q][k] + CNT_W'(1);
            end
        end
    end

endmodule : pwr_top

// File: pwr_top_properties.sv
// Bus and decision timing checks for the policing block
`timescale 1ns/100ps
module pwr_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        pkt_valid,
    input wire logic        res_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire logic take = hsel && htrans[1] && hready && ce;
    // Reads pay exactly two wait states
    sequence wait_s; !hreadyout [*2] ##1 hreadyout; endsequence
    read_wait_a: assert property (take && !hwrite |=> wait_s)
        else $error("read wait wrong");
    write_fast_a: assert property (take && hwrite |=> hreadyout)
        else $error("write waited");
    idle_ready_a: assert property (hreadyout && !take |=> hreadyout)
        else $error("idle wait state");
    wait_limit_a: assert property (!hreadyout [*2] |=> hreadyout) else $error("long wait");
    okay_resp_a: assert property (!hresp) else $error("error response");
    data_hold_a: assert property (!hreadyout |-> $stable(hrdata)) else $error("data moved");
    res_delay_a: assert property (pkt_valid && ce |-> ##2 res_valid) else $error("late");
    res_cause_a: assert property (res_valid |-> $past(pkt_valid, 2)) else $error("stray");
endmodule : pwr_checker

bind pwr_top pwr_checker chk_i (.clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pkt_valid(pkt_valid), .res_valid(res_valid));

// File: port_policing_wred_config_test.sv
// Self-checking bench for the policing and drop register block
`timescale 1ns/100ps
module port_policing_wred_config_test import pwr_pkg::*; ();
    logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, pkt_valid = 1'b0;
    logic        pkt_is_ip = 1'b0, pkt_srp = 1'b0, hreadyout, hresp, res_valid, res_drop, res_mark;
    logic [1:0]  htrans = 2'h0, pkt_col = 2'h0, pkt_q = 2'h0, res_colour, res_q;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
    logic [15:0] pkt_len = 16'h0000, pkt_rand = 16'hffff;
    logic [10:0] mem_avg = 11'h040;
    int          n_mismatch = 0, comparisons = 0;
    pwr_top dut (.clk(clk), .rst(rst), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pkt_valid(pkt_valid), .pkt_queue(pkt_q),
        .pkt_len(pkt_len), .pkt_is_ip(pkt_is_ip), .pkt_dscp_colour(pkt_col), .pkt_srp(pkt_srp),
        .pkt_rand(pkt_rand), .pkt_queue_avg(11'h012), .mem_avg_size(mem_avg),
        .res_valid(res_valid), .res_queue(res_q), .res_colour(res_colour), .res_drop(res_drop),
        .res_mark(res_mark));
    initial forever #5 clk = ~clk;
    initial
    begin
        repeat (4000) @(posedge clk);
        stop_test(1);
    end
    task automatic stop_test(int late);
        n_mismatch += late;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        n_mismatch += int'(got !== exp);
        if (got !== exp) $display("wrong value %s expected %h seen %h", name, exp, got);
    endtask : chk
    // Address phase held until hready, then data phase until hready again
    task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge clk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 20'h0_0000, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task automatic rdck(logic [11:0] a, logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk($sformatf("register %h", a), exp, rd);
    endtask : rdck
    // Result is checked 1 ns after the edge that registers it
    task automatic pkt(logic [15:0] len, logic ip, logic srp, logic [1:0] col, logic [4:0] exp);
        @(posedge clk);
        {pkt_valid, pkt_len, pkt_is_ip, pkt_srp, pkt_col} <= {1'b1, len, ip, srp, col};
        @(posedge clk);
        pkt_valid <= 1'b0;
        @(posedge clk);
        #1 chk("decision", {25'h000_0000, pkt_q, exp},
               {25'h000_0000, res_q, res_valid, res_colour, res_drop, res_mark});
    endtask : pkt
    task automatic defaults_and_masks();
        rdck(OFS_CONTROL, 32'h0000_0020);
        rdck(OFS_RATE, 32'h1000_2000);
        rdck(OFS_BURST, 32'h1000_3000);
        rdck(OFS_MEM_THR, 32'h0400_0080);
        rdck(OFS_Q_THR, 32'h0080_0009);
        rdck(OFS_Q_SCALE, 32'h0010_0000);
        rdck(12'h900, 32'h0000_0000);
        xfer(1'b1, OFS_Q_SCALE, 32'hffff_ffff);
        rdck(OFS_Q_SCALE, 32'h07ff_0000);
        xfer(1'b1, OFS_MEM_SCALE, 32'hffff_ffff);
        rdck(OFS_MEM_SCALE, 32'h07ff_0040);
    endtask : defaults_and_masks
    task automatic indirect_entries();
        xfer(1'b1, OFS_POINTER, 32'h0002_0003);
        xfer(1'b1, OFS_RATE, 32'h1234_5678);
        xfer(1'b1, OFS_POINTER, 32'h0002_0002);
        rdck(OFS_RATE, 32'h1000_2000);
        xfer(1'b1, OFS_POINTER, 32'h0004_0003);
        rdck(OFS_RATE, 32'h1000_2000);
        xfer(1'b1, OFS_POINTER, 32'h0002_0003);
        rdck(OFS_RATE, 32'h1234_5678);
    endtask : indirect_entries
    task automatic decisions();
        xfer(1'b1, OFS_CONTROL, 32'h0000_0060);
        pkt(16'h0064, 1'b0, 1'b0, 2'h2, 5'h1c);
        xfer(1'b1, OFS_CONTROL, 32'h0000_0013);
        pkt(16'h0064, 1'b1, 1'b0, 2'h3, 5'h15);
        pkt(16'hffff, 1'b1, 1'b0, 2'h1, 5'h1f);
        xfer(1'b1, OFS_CONTROL, 32'h0000_0009);
        pkt(16'hffff, 1'b1, 1'b0, 2'h1, 5'h1e);
        xfer(1'b1, OFS_MEM_SCALE, 32'h0000_0000);
        mem_avg <= 11'h7ff;
        xfer(1'b1, OFS_CONTROL, 32'h0000_0403);
        pkt(16'h0064, 1'b1, 1'b1, 2'h1, 5'h14);
        pkt(16'h0064, 1'b1, 1'b0, 2'h1, 5'h16);
        xfer(1'b1, OFS_CONTROL, 32'h0000_0003);
        pkt(16'h0064, 1'b1, 1'b0, 2'h1, 5'h14);
    endtask : decisions
    // Queue 0 saw four green, three dropped and two red packets above
    task automatic counters();
        xfer(1'b1, OFS_CONTROL, 32'h0000_0803);
        pkt_q <= 2'h3;
        pkt(16'h0064, 1'b1, 1'b0, 2'h1, 5'h14);
        xfer(1'b1, OFS_POINTER, 32'h0001_0003);
        rdck(OFS_POINTER, 32'h0001_0003);
        xfer(1'b1, OFS_CONTROL, 32'h0000_0100);
        rdck(OFS_COUNTER, 32'h0000_0000);
        rdck(OFS_Q_SCALE, 32'h0010_0012);
        xfer(1'b1, OFS_POINTER, 32'h0001_0000);
        rdck(OFS_COUNTER, 32'h0000_0004);
        xfer(1'b1, OFS_CONTROL, 32'h0000_0300);
        rdck(OFS_COUNTER, 32'h0000_0002);
        xfer(1'b1, OFS_CONTROL, 32'h0000_0000);
        rdck(OFS_COUNTER, 32'h0000_0003);
    endtask : counters
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        defaults_and_masks();
        indirect_entries();
        decisions();
        counters();
        stop_test(0);
    end
endmodule : port_policing_wred_config_test
